/* core/uart_receive_buffer_flags.sv */
module uart_receive_buffer_flags (
  input  wire logic                           CLK_SYS,
  input  wire logic                           RST,
  input  wire logic [uart_rx_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [uart_rx_pkg::DATA_W-1:0] WDATA,
  input  wire logic                           WR,
  input  wire logic                           RD,
  input  wire logic                           SERIAL_RX_PIN,
  output logic      [uart_rx_pkg::DATA_W-1:0] RDATA,
  output logic                                RX_IRQ,
  output logic                                RX_PIN_OVERRIDE
);
  import uart_rx_pkg::*;

  typedef struct packed {
    logic [2:0]             sync;
    logic                   line;
    rx_state_t              st;
    logic [7:0]             div_cnt;
    logic [3:0]             phase;
    logic [3:0]             bitn;
    logic [8:0]             shift;
    logic                   par;
    logic                   fe;
    logic                   dor_pend;
    rx_entry_t [1:0]        fifo;
    logic                   head;
    logic [1:0]             count;
    logic [DATA_W-1:0]      ctl_b;
    logic [DATA_W-1:0]      ctl_c;
    logic [DATA_W-1:0]      baud;
    logic [DATA_W-1:0]      rdata;
    logic                   irq;
    logic                   ovr;
  } state_t;

  state_t q;
  state_t d;

  logic       rxen;
  logic       pen;
  logic [2:0] size;
  logic [3:0] nbits;
  logic       tick;
  logic       sample;
  logic       pop;
  logic       push;
  logic       has_room;
  logic       tail;
  rx_entry_t  head_e;
  rx_entry_t  new_e;

  // decoded settings and helpers
  always_comb begin
    rxen     = q.ctl_b[B_RXEN];
    pen      = q.ctl_c[C_PEN];
    size     = {q.ctl_b[B_SIZE2], q.ctl_c[C_SIZE1], q.ctl_c[C_SIZE0]};
    if (size == SIZE_NINE) begin
      nbits = BITS_NINE;
    end else if (size <= SIZE_EIGHT) begin
      nbits = BITS_FIVE + {1'b0, size};
    end else begin
      nbits = BITS_EIGHT;
    end
    tick     = rxen && (q.div_cnt == q.baud);
    sample   = tick && (q.phase == PHASE_MID);
    head_e   = q.fifo[q.head];
    tail     = q.head ^ q.count[0];
    has_room = (q.count != FIFO_FULL);
    pop      = RD && (ADDR == OFS_DATA) && (q.count != 2'h0);
    // entry carries char, stop bit, overrun and parity result
    new_e.ninth = q.shift[8];
    new_e.data  = q.shift[7:0];
    new_e.fe    = q.fe;
    new_e.dor   = q.dor_pend;
    new_e.upe   = pen && (^q.shift ^ q.par ^ q.ctl_c[C_PODD]);
  end

  // next-state logic
  always_comb begin
    d    = q;
    push = 1'b0;

    // three-stage pin sync, level accepted when stages two and three agree
    d.sync = {q.sync[1:0], SERIAL_RX_PIN};
    if (q.sync[1] == q.sync[2]) begin
      d.line = q.sync[2];
    end

    // tick divider and bit phase
    if (tick) begin
      d.div_cnt = 8'h00;
      d.phase   = (q.phase == PHASE_LAST) ? 4'h0 : q.phase + 4'h1;
    end else if (rxen) begin
      d.div_cnt = q.div_cnt + 8'h01;
    end

    // receive state machine
    case (q.st)
      ST_IDLE: begin
        if (!q.line) begin
          d.st      = ST_START;
          d.phase   = 4'h0;
          d.div_cnt = 8'h00;
        end
      end
      ST_START: begin
        if (sample) begin
          d.st    = q.line ? ST_IDLE : ST_DATA;
          d.bitn  = 4'h0;
          d.shift = 9'h000;
        end
      end
      ST_DATA: begin
        if (sample) begin
          d.shift[q.bitn] = q.line;
          d.bitn          = q.bitn + 4'h1;
          if (q.bitn == nbits - 4'h1) begin
            d.st = pen ? ST_PARITY : ST_STOP;
          end
        end
      end
      ST_PARITY: begin
        if (sample) begin
          d.par = q.line;
          d.st  = ST_STOP;
        end
      end
      ST_STOP: begin
        // only the first stop bit is looked at
        if (sample) begin
          d.fe = !q.line;
          d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (has_room || pop) begin
          push       = 1'b1;
          d.dor_pend = 1'b0;
          d.st       = ST_IDLE;
        end else if (!q.line) begin
          // waiting frame lost to a new start
          d.dor_pend = 1'b1;
          d.st       = ST_START;
          d.phase    = 4'h0;
          d.div_cnt  = 8'h00;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // buffer push and pop
    if (push) begin
      // tail is the free slot, also when a full buffer pops in the same cycle
      d.fifo[tail] = new_e;
    end
    if (pop) begin
      d.head = ~q.head;
    end
    d.count = q.count + {1'b0, push} - {1'b0, pop};

    // register writes; status a flags are not writable
    if (WR) begin
      case (ADDR)
        OFS_CTRL_B: d.ctl_b = (WDATA & B_WMASK) | (q.ctl_b & ~B_WMASK);
        OFS_CTRL_C: d.ctl_c = (WDATA & C_WMASK) | (q.ctl_c & ~C_WMASK);
        OFS_BAUD:   d.baud  = WDATA;
        default:    d.ctl_b = q.ctl_b;
      endcase
    end

    // disabled receiver: abandon frame and flush buffer
    if (!rxen) begin
      d.st       = ST_IDLE;
      d.count    = 2'h0;
      d.head     = 1'b0;
      d.dor_pend = 1'b0;
      d.div_cnt  = 8'h00;
      d.phase    = 4'h0;
    end

    // read data, valid only in the cycle after the strobe
    d.rdata = '0;
    if (RD) begin
      case (ADDR)
        OFS_CTRL_A: begin
          d.rdata[A_RXC] = (q.count != 2'h0);
          d.rdata[A_FE]  = (q.count != 2'h0) && head_e.fe;
          d.rdata[A_DOR] = (q.count != 2'h0) && head_e.dor;
          d.rdata[A_UPE] = (q.count != 2'h0) && head_e.upe && pen;
        end
        OFS_CTRL_B: begin
          d.rdata         = q.ctl_b;
          d.rdata[B_RXB8] = (q.count != 2'h0) && head_e.ninth;
        end
        OFS_CTRL_C: d.rdata = q.ctl_c;
        OFS_DATA:   d.rdata = (q.count != 2'h0) ? head_e.data : '0;
        OFS_BAUD:   d.rdata = q.baud;
        default:    d.rdata = '0;
      endcase
    end

    // interrupt from buffer content only, never from error flags
    d.irq = d.ctl_b[B_RXCIE] && (d.count != 2'h0);
    d.ovr = d.ctl_b[B_RXEN];
  end

  // state register
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      q          <= '0;
      q.sync     <= 3'h7;
      q.line     <= 1'b1;
      q.st       <= ST_IDLE;
      q.ctl_b    <= B_RST;
      q.ctl_c    <= C_RST;
      q.baud     <= BAUD_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign RDATA           = q.rdata;
  assign RX_IRQ          = q.irq;
  assign RX_PIN_OVERRIDE = q.ovr;

endmodule : uart_receive_buffer_flags

/* pkg/uart_rx_pkg.sv */
package uart_rx_pkg;

  // register port widths
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL_A = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CTRL_C = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_DATA   = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_BAUD   = 3'h4;

  // serial_ctrl_status_a bit positions
  localparam int A_RXC = 7;
  localparam int A_FE  = 4;
  localparam int A_DOR = 3;
  localparam int A_UPE = 2;

  // serial_ctrl_status_b bit positions
  localparam int B_RXCIE = 7;
  localparam int B_RXEN  = 4;
  localparam int B_SIZE2 = 2;
  localparam int B_RXB8  = 1;
  localparam int B_TXB8  = 0;

  // serial_ctrl_status_c bit positions
  localparam int C_PEN   = 5;
  localparam int C_PODD  = 4;
  localparam int C_STOP  = 3;
  localparam int C_SIZE1 = 2;
  localparam int C_SIZE0 = 1;

  // software-writable bits and reset values
  localparam logic [DATA_W-1:0] B_WMASK  = 8'h95;
  localparam logic [DATA_W-1:0] C_WMASK  = 8'h3e;
  localparam logic [DATA_W-1:0] B_RST    = 8'h00;
  localparam logic [DATA_W-1:0] C_RST    = 8'h06;
  localparam logic [DATA_W-1:0] BAUD_RST = 8'h00;

  // character size codes
  localparam logic [2:0] SIZE_NINE  = 3'h7;
  localparam logic [2:0] SIZE_FIVE  = 3'h0;
  localparam logic [2:0] SIZE_EIGHT = 3'h3;
  localparam logic [3:0] BITS_FIVE  = 4'h5;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE  = 4'h9;

  // sampling: 16 ticks per bit, decision on tick 7
  localparam logic [3:0] PHASE_LAST = 4'hf;
  localparam logic [3:0] PHASE_MID  = 4'h7;

  // receive buffer depth
  localparam logic [1:0] FIFO_FULL = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DATA   = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP   = 3'b100,
    ST_WAIT   = 3'b101
  } rx_state_t;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
    logic       fe;
    logic       dor;
    logic       upe;
  } rx_entry_t;

endpackage : uart_rx_pkg

/* test/serial_tx_model.sv */
module serial_tx_model (
  input  wire logic clk,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT_CLKS = 16;
  // line idles high
  initial pin = 1'b1;
  // start, data lsb first, optional parity, stop, one idle bit (two without parity)
  task automatic send(input logic [8:0] d, input int n, input logic pen, input logic par,
                      input logic stp);
    logic [12:0] f;
    f = 13'h1fff;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++) f[i+1] = d[i];
    f[n+1] = pen ? par : stp;
    f[n+2] = pen ? stp : 1'b1; // stop bit when parity is on, else an extra idle bit
    for (int i = 0; i < n + 4; i++) begin
      @(posedge clk);
      pin <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
  endtask : send
endmodule : serial_tx_model

/* test/test_uart_receive_buffer_flags.sv */
module test_uart_receive_buffer_flags;
  import uart_rx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       CLK_SYS = 0;
  logic       RST = 1;
  logic       WR = 0;
  logic       RD = 0;
  logic       pin;
  logic [2:0] ADDR = 0;
  logic [7:0] WDATA = 0;
  logic [7:0] RDATA;
  logic [7:0] v;
  logic       RX_IRQ;
  logic       RX_PIN_OVERRIDE;
  int         bad_count = 0;
  int         tests_run = 0;
  int         seed = 24;
  // 25 MHz system clock
  always #20 CLK_SYS = ~CLK_SYS;
  serial_tx_model tx (.clk(CLK_SYS), .pin(pin));
  uart_receive_buffer_flags uut (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .SERIAL_RX_PIN(pin), .RDATA(RDATA), .RX_IRQ(RX_IRQ),
    .RX_PIN_OVERRIDE(RX_PIN_OVERRIDE));
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one register cycle, read data kept in v
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    WR <= w;
    RD <= !w;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK_SYS);
    WR <= 1'b0;
    RD <= 1'b0;
    #1 v = RDATA;
  endtask : acc
  // expected status a after one frame: complete, stop and parity result
  function automatic logic [7:0] exp_flags(input logic stp, input logic pen, input logic pbad);
    exp_flags = {1'b1, 2'b0, !stp, 1'b0, pen & pbad, 2'b0};
  endfunction : exp_flags
  task automatic wait_n(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask : wait_n
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // hang guard, far beyond the expected run
  initial begin
    #3ms;
    bad_count++;
    wrap_up();
  end
  // main sequence
  initial begin
    int n;
    logic [8:0] d;
    logic [2:0] sz;
    logic pen, podd, stp, pbad;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    acc(0, OFS_CTRL_A, 0);
    chk(v, 8'h00);
    acc(0, OFS_CTRL_C, 0);
    chk(v, C_RST);
    acc(0, 3'h5, 0);
    chk(v, 8'h00);
    for (int k = 0; k < 15; k++) begin
      n = 5 + k % 5;
      sz = n == 9 ? SIZE_NINE : 3'(n - 5);
      pen = k % 3 != 0;
      podd = k % 3 == 2;
      d = 9'($random(seed)) & ((9'h1 << n) - 9'h1);
      stp = k < 10 || 1'($random(seed));
      pbad = 1'($random(seed));
      acc(1, OFS_CTRL_C, {2'b0, pen, podd, k[0], sz[1:0], 1'b0});
      acc(1, OFS_CTRL_B, {4'h9, 1'b0, sz[2], 2'b0});
      tx.send(d, n, pen, ^d ^ podd ^ pbad, stp);
      acc(0, OFS_CTRL_A, 0);
      chk(v, exp_flags(stp, pen, pbad));
      acc(1, OFS_CTRL_A, 8'h00);
      acc(0, OFS_CTRL_A, 0);
      chk(v, exp_flags(stp, pen, pbad));
      acc(0, OFS_CTRL_B, 0);
      chk(v, {4'h9, 1'b0, sz[2], d[8], 1'b0});
      acc(0, OFS_DATA, 0);
      chk(v, d[7:0]);
      acc(0, OFS_CTRL_A, 0);
      chk(v, 8'h00);
      chk({7'h0, RX_IRQ}, 8'h00);
    end
    // third frame lost while two wait unread
    acc(1, OFS_CTRL_C, 8'h06);
    acc(1, OFS_CTRL_B, 8'h90);
    for (int i = 0; i < 4; i++) tx.send(9'(8'ha0 + i), 8, 1'b0, 1'b0, 1'b1);
    acc(0, OFS_DATA, 0);
    chk(v, 8'ha0);
    wait_n(3);
    acc(0, OFS_CTRL_A, 0);
    chk(v, 8'h80);
    acc(0, OFS_DATA, 0);
    acc(0, OFS_CTRL_A, 0);
    chk(v, 8'h88);
    acc(0, OFS_DATA, 0);
    chk(v, 8'ha3);
    acc(0, OFS_CTRL_A, 0);
    chk(v, 8'h00);
    tx.send(9'h55, 8, 1'b0, 1'b0, 1'b1);
    acc(0, OFS_CTRL_A, 0);
    chk(v, 8'h80);
    chk({7'h0, RX_IRQ}, 8'h01);
    acc(1, OFS_CTRL_B, 8'h80);
    wait_n(2);
    chk({6'h0, RX_IRQ, RX_PIN_OVERRIDE}, 8'h00);
    // disable in mid frame, then look for leftovers
    acc(1, OFS_CTRL_B, 8'h90);
    fork
      tx.send(9'h3c, 8, 1'b0, 1'b0, 1'b1);
      begin
        wait_n(60);
        acc(1, OFS_CTRL_B, 8'h00);
      end
    join
    acc(1, OFS_CTRL_B, 8'h90);
    acc(0, OFS_CTRL_A, 0);
    chk(v, 8'h00);
    wrap_up();
  end
endmodule : test_uart_receive_buffer_flags
bind uart_receive_buffer_flags uart_receive_buffer_flags_monitor mon (.CLK_SYS(CLK_SYS),
  .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .SERIAL_RX_PIN(SERIAL_RX_PIN),
  .RDATA(RDATA), .RX_IRQ(RX_IRQ), .RX_PIN_OVERRIDE(RX_PIN_OVERRIDE));

/* test/uart_receive_buffer_flags_monitor.sv */
module uart_receive_buffer_flags_monitor (
  input wire logic                           CLK_SYS,
  input wire logic                           RST,
  input wire logic [uart_rx_pkg::ADDR_W-1:0] ADDR,
  input wire logic [uart_rx_pkg::DATA_W-1:0] WDATA,
  input wire logic                           WR,
  input wire logic                           RD,
  input wire logic                           SERIAL_RX_PIN,
  input wire logic [uart_rx_pkg::DATA_W-1:0] RDATA,
  input wire logic                           RX_IRQ,
  input wire logic                           RX_PIN_OVERRIDE
);
  import uart_rx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] b_q;
  logic [7:0] c_q;
  // shadow of the control bytes written on the port
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      b_q <= B_RST;
      c_q <= C_RST;
    end else begin
      if (WR && ADDR == OFS_CTRL_B) b_q <= WDATA;
      if (WR && ADDR == OFS_CTRL_C) c_q <= WDATA;
    end
  end
  // decoded status a read strobe and the five-bit size
  wire logic rd_a = RD && ADDR == OFS_CTRL_A;
  wire logic five = {b_q[B_SIZE2], c_q[C_SIZE1], c_q[C_SIZE0]} == SIZE_FIVE;
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  // flag read, flag write, flag read again
  sequence s_rewrite;
    rd_a ##1 (WR && ADDR == OFS_CTRL_A && RDATA[A_RXC]) ##1 rd_a;
  endsequence
  sequence s_off;
    WR && ADDR == OFS_CTRL_B && !WDATA[B_RXEN];
  endsequence
  a_reset_quiet: assert property ($fell(RST) |-> RDATA == 8'h00 && !RX_IRQ && !RX_PIN_OVERRIDE)
    else $error("outputs not quiet after reset");
  a_pin_release: assert property (WR && ADDR == OFS_CTRL_B |=> RX_PIN_OVERRIDE == b_q[B_RXEN])
    else $error("pin override does not follow enable");
  a_flush_empty: assert property (s_off |=> ##1 !RX_IRQ)
    else $error("buffer not flushed by disable");
  a_irq_mask: assert property (WR && ADDR == OFS_CTRL_B && !WDATA[B_RXCIE] |=> ##1 !RX_IRQ)
    else $error("irq without enable");
  a_irq_flag: assert property (rd_a && b_q[B_RXCIE] |=> RDATA[A_RXC] == $past(RX_IRQ))
    else $error("irq differs from complete flag");
  a_irq_gated: assert property (RX_IRQ |-> b_q[B_RXCIE])
    else $error("irq raised while disabled");
  a_parity_off: assert property (rd_a && !c_q[C_PEN] |=> RDATA[A_UPE] == 1'b0)
    else $error("parity flag set while unchecked");
  a_size_mask: assert property (RD && ADDR == OFS_DATA && five |=> RDATA[7:5] == 3'h0)
    else $error("unused data bits not zero");
  a_flags_kept: assert property (s_rewrite |=> RDATA == $past(RDATA, 2))
    else $error("flags changed by a write");
endmodule : uart_receive_buffer_flags_monitor
